/* File: hw/csc_pkg.sv */
// Package: register map, field positions and constants of the serial channel
package csc_pkg;
	localparam logic [2:0] ADDR_MAIN  = 3'h0;
	localparam logic [2:0] ADDR_CLOCK = 3'h1;
	localparam logic [2:0] ADDR_LEN   = 3'h2;
	localparam logic [2:0] ADDR_STAT  = 3'h3;
	localparam logic [2:0] ADDR_TX    = 3'h4;
	localparam logic [2:0] ADDR_RX    = 3'h5;
	localparam int POS_PWR   = 7;
	localparam int POS_TXE   = 6;
	localparam int POS_RXE   = 5;
	localparam int POS_DIR   = 4;
	localparam int POS_SCE   = 0;
	localparam int POS_CKP   = 4;
	localparam int POS_DAP   = 3;
	localparam int POS_CL3   = 3;
	localparam int POS_TSF   = 7;
	localparam int POS_OVE   = 0;
	localparam logic [7:0] MAIN_RST  = 8'h00;
	localparam logic [7:0] CLOCK_RST = 8'h00;
	localparam logic [7:0] LEN_RST   = 8'h00;
	localparam logic [2:0] CKS_SLAVE = 3'h7;
	localparam logic [4:0] LEN_BASE  = 5'h08;
	localparam logic [4:0] LEN_MAX   = 5'h10;
	localparam logic [4:0] WORD_BITS = 5'h10;
	typedef enum {CSC_IDLE, CSC_RUN, CSC_DRAIN} csc_state_t;
endpackage

/* File: hw/csc_sync2.sv */
// Two-stage synchroniser for the serial clock and serial input pins
`timescale 1ns/1ps
module csc_sync2 (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Pins in, synchronised levels out
	input  wire logic [1:0] pin_in,
	output logic      [1:0] pin_sync
);
	logic [1:0] meta;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta     <= 2'h3;
			pin_sync <= 2'h3;
		end else begin
			meta     <= pin_in;
			pin_sync <= meta;
		end
	end
endmodule

/* File: hw/csc_clk_div.sv */
// Half-period tick generator for the master serial clock
`timescale 1ns/1ps
module csc_clk_div (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] clock_source_select,
	// Tick once per half serial clock period
	output logic            tick
);
	logic [6:0] cnt;
	logic [6:0] limit;

	// Code 000 gives a tick every cycle: serial clock at half the bus clock
	assign limit = (7'h01 << clock_source_select) - 7'h01;
	assign tick  = run && (cnt == limit);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 7'h00;
		end else if (!run || tick) begin
			cnt <= 7'h00;
		end else begin
			cnt <= cnt + 7'h01;
		end
	end
endmodule

/* File: hw/csc_channel.sv */
// Clocked serial channel, single transfer mode, master or slave
//
// Contract
// - 00H to clock control: master, half clock
// - 07H to clock control: slave, external clock
// - 00H to length control: 8-bit frames
// - Polarity and phase 00 give type 1
// - Bit order select 0 shifts MSB first
// - C1H: clock on, transmit only, MSB first
// - A1H: clock on, receive only, MSB first
// - E1H: clock on, transmit and receive
// - Transmit write sets busy, master starts frame
// - Slave waits idle for external clock edges
// - Receive-only dummy read sets busy, starts frame
// - Master drives clock and data out
// - Receiver samples input with serial clock
// - Frame end: stop, interrupt, clear busy
// - Slave ignores clock after frame end
// - Receive read with trigger enable restarts
// - Trigger enable 0: read starts nothing
// - Length 8 to 16, right-aligned, zero fill
// - Overrun on unread word; write 0 clears
// - Transmit-enable interrupt never raised
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module csc_channel
	import csc_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [2:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	// Serial pins
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe,
	output logic             serial_output_pin,
	input  wire logic        serial_input_pin,
	// Interrupt requests
	output logic             reception_complete_irq,
	output logic             transmission_enable_irq
);
	logic [7:0]  serial_main_control;
	logic [7:0]  serial_clock_control, serial_length_control;
	logic        transfer_active_flag, overrun_flag, rx_unread;
	logic [15:0] transmit_buffer, receive_buffer, rx_aligned;
	logic [15:0] tx_sh, rx_sh, next_rx_sh;
	logic [4:0]  bit_cnt, frame_len;
	logic [3:0]  msb_idx;
	logic [2:0]  clock_source_select;
	logic [1:0]  samp_pipe, last_pipe, pin_sync;
	logic        sck_q, sck_prev, tick;
	logic        unit_power_bit, transmit_enable_bit, receive_enable_bit;
	logic        bit_order_select, start_trigger_enable;
	logic        clock_polarity_bit, slave, tx_start, rx_start, start;
	logic        rd_rx, sck_lvl, s_rise, s_fall, drive_ev, rise_ev;
	logic        last_bit, cap, done;
	csc_state_t  state;

	assign unit_power_bit       = serial_main_control[POS_PWR];
	assign transmit_enable_bit  = serial_main_control[POS_TXE];
	assign receive_enable_bit   = serial_main_control[POS_RXE];
	assign bit_order_select     = serial_main_control[POS_DIR];
	assign start_trigger_enable = serial_main_control[POS_SCE];
	assign clock_polarity_bit   = serial_clock_control[POS_CKP];
	assign clock_source_select  = serial_clock_control[2:0];
	assign slave     = clock_source_select == CKS_SLAVE;
	// Codes 1xxx all give 16 bits
	assign frame_len = serial_length_control[POS_CL3] ? LEN_MAX :
		LEN_BASE + {2'b00, serial_length_control[2:0]};
	assign msb_idx   = 4'(frame_len - 5'h01);

	// A transmit write during a frame is ignored and starts nothing
	assign tx_start = wr && (addr == ADDR_TX) && unit_power_bit &&
		transmit_enable_bit && !transfer_active_flag;
	assign rd_rx    = rd && (addr == ADDR_RX);
	assign rx_start = rd_rx && unit_power_bit && receive_enable_bit &&
		!transmit_enable_bit && start_trigger_enable &&
		!transfer_active_flag;
	assign start    = tx_start || rx_start;

	csc_sync2 u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pin_in   ({serial_clock_pin_in, serial_input_pin}),
		.pin_sync (pin_sync)
	);

	csc_clk_div u_div (
		.sys_clk             (sys_clk),
		.rst_n               (rst_n),
		.run                 ((state == CSC_RUN) && !slave),
		.clock_source_select (clock_source_select),
		.tick                (tick)
	);

	// Normalised clock: idle high, data driven on fall, sampled on rise
	assign sck_lvl = pin_sync[1] ^ clock_polarity_bit;
	assign s_fall  = sck_prev && !sck_lvl;
	assign s_rise  = !sck_prev && sck_lvl;
	// Edges outside RUN are never looked at in slave mode
	assign drive_ev = (state == CSC_RUN) &&
		(slave ? s_fall : (tick && sck_q));
	assign rise_ev  = (state == CSC_RUN) &&
		(slave ? s_rise : (tick && !sck_q));
	assign last_bit = bit_cnt == msb_idx[3:0] + 5'h00;
	// The data input lags its pin by two flops; in master mode the sample
	// is delayed by the same two cycles so it lines up with our own edge
	assign cap  = slave ? rise_ev : samp_pipe[1];
	assign done = (state != CSC_IDLE) &&
		(slave ? (rise_ev && last_bit) : (samp_pipe[1] && last_pipe[1]));
	assign next_rx_sh = bit_order_select ? {pin_sync[0], rx_sh[15:1]} :
		{rx_sh[14:0], pin_sync[0]};
	// LSB-first words arrive at the top and are moved down to bit 0
	assign rx_aligned = bit_order_select ?
		(next_rx_sh >> (WORD_BITS - frame_len)) : next_rx_sh;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= CSC_IDLE;
		end else if (!unit_power_bit) begin
			state <= CSC_IDLE;
		end else begin
			case (state)
			CSC_IDLE: begin
				if (start) begin
					state <= CSC_RUN;
				end
			end
			CSC_RUN: begin
				if (slave && done) begin
					state <= CSC_IDLE;
				end else if (!slave && rise_ev && last_bit) begin
					state <= CSC_DRAIN;
				end
			end
			CSC_DRAIN: begin
				if (done) begin
					state <= CSC_IDLE;
				end
			end
			default: state <= CSC_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 5'h00;
		end else if (start) begin
			bit_cnt <= 5'h00;
		end else if (rise_ev) begin
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// Master clock rests high outside a frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_q <= 1'b1;
		end else if ((state != CSC_RUN) || slave) begin
			sck_q <= 1'b1;
		end else if (tick) begin
			sck_q <= !sck_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_prev  <= 1'b1;
			samp_pipe <= 2'h0;
			last_pipe <= 2'h0;
		end else begin
			sck_prev  <= sck_lvl;
			samp_pipe <= {samp_pipe[0], rise_ev && !slave};
			last_pipe <= {last_pipe[0], rise_ev && !slave && last_bit};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh             <= 16'h0000;
			serial_output_pin <= 1'b1;
		end else begin
			if (tx_start) begin
				tx_sh <= wdata;
			end else if (rise_ev) begin
				tx_sh <= bit_order_select ? (tx_sh >> 1) : (tx_sh << 1);
			end
			if (drive_ev) begin
				serial_output_pin <= bit_order_select ?
					tx_sh[0] : tx_sh[msb_idx];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sh <= 16'h0000;
		end else if (start) begin
			rx_sh <= 16'h0000;
		end else if (cap && receive_enable_bit) begin
			rx_sh <= next_rx_sh;
		end
	end

	// Busy flag: set by the start, cleared by done (slave: at the last edge; master: two cycles after it)
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			transfer_active_flag <= 1'b0;
		end else if (!unit_power_bit) begin
			transfer_active_flag <= 1'b0;
		end else if (start) begin
			transfer_active_flag <= 1'b1;
		end else if (done) begin
			transfer_active_flag <= 1'b0;
		end
	end

	// Raised in every single-transfer frame, transmit-only included
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reception_complete_irq <= 1'b0;
		end else begin
			reception_complete_irq <= done && unit_power_bit;
		end
	end
	assign transmission_enable_irq = 1'b0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			receive_buffer <= 16'h0000;
		end else if (done && receive_enable_bit) begin
			receive_buffer <= rx_aligned;
		end
	end

	// A completion and a read in one cycle leave the new word unread
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_unread <= 1'b0;
		end else if (!unit_power_bit) begin
			rx_unread <= 1'b0;
		end else if (done && receive_enable_bit) begin
			rx_unread <= 1'b1;
		end else if (rd_rx) begin
			rx_unread <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_flag <= 1'b0;
		end else if (!unit_power_bit) begin
			overrun_flag <= 1'b0;
		end else if (done && receive_enable_bit && rx_unread) begin
			overrun_flag <= 1'b1;
		end else if (wr && (addr == ADDR_STAT) && !wdata[POS_OVE]) begin
			overrun_flag <= 1'b0;
		end
	end

	// Clock settings are locked while the unit is powered; length settings only while powered with transmit or receive enabled
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_main_control   <= MAIN_RST;
			serial_clock_control  <= CLOCK_RST;
			serial_length_control <= LEN_RST;
			transmit_buffer       <= 16'h0000;
		end else if (wr) begin
			if (addr == ADDR_MAIN) begin
				serial_main_control <= wdata[7:0];
			end
			if ((addr == ADDR_CLOCK) && !unit_power_bit) begin
				serial_clock_control <= {3'h0, wdata[4:0]};
			end
			if ((addr == ADDR_LEN) && (!unit_power_bit ||
				(!transmit_enable_bit && !receive_enable_bit))) begin
				serial_length_control <= {4'h0, wdata[3:0]};
			end
			if ((addr == ADDR_TX) && !transfer_active_flag) begin
				transmit_buffer <= wdata;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			case (addr)
			ADDR_MAIN:  rdata <= {8'h00, serial_main_control};
			ADDR_CLOCK: rdata <= {8'h00, serial_clock_control};
			ADDR_LEN:   rdata <= {8'h00, serial_length_control};
			ADDR_STAT:  rdata <= {8'h00, transfer_active_flag, 6'h00,
				overrun_flag};
			ADDR_TX:    rdata <= transmit_buffer;
			ADDR_RX:    rdata <= receive_buffer;
			default:    rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end

	assign serial_clock_pin_out = sck_q ^ clock_polarity_bit;
	assign serial_clock_pin_oe  = unit_power_bit && !slave;
	// Helper for the checks: master clock rising edges seen in a frame
	logic [4:0] edge_cnt;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_cnt <= 5'h00;
		end else if (start) begin
			edge_cnt <= 5'h00;
		end else if (!slave && (state == CSC_RUN) && tick && !sck_q) begin
			edge_cnt <= edge_cnt + 5'h01;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_tx_write;
		tx_start && !slave;
	endsequence
	sequence s_clock_moves;
		##[1:130] (serial_clock_pin_oe && !serial_clock_pin_out);
	endsequence

	busy_set_a: assert property (start |=> transfer_active_flag)
		else $error("busy flag not set after start");
	master_start_a: assert property (s_tx_write |-> s_clock_moves)
		else $error("master clock did not start");
	irq_pulse_a: assert property (reception_complete_irq |=>
		!reception_complete_irq)
		else $error("completion interrupt longer than one cycle");
	end_clears_a: assert property (reception_complete_irq |->
		!transfer_active_flag && serial_clock_pin_out)
		else $error("frame end left busy set or clock low");
	frame_len_a: assert property (reception_complete_irq && !slave |->
		edge_cnt == frame_len)
		else $error("wrong number of clock edges in frame");
	no_trig_a: assert property (rd_rx && !start_trigger_enable &&
		!transfer_active_flag |=> !transfer_active_flag)
		else $error("receive read started a frame without trigger");
	slave_wait_a: assert property (slave && (state == CSC_RUN) &&
		unit_power_bit && !s_rise && !s_fall |=> (state == CSC_RUN) &&
		$stable(bit_cnt))
		else $error("slave moved without clock edges");
	slave_quiet_a: assert property (slave |-> !serial_clock_pin_oe)
		else $error("slave drove the clock pin");
	ovr_clear_a: assert property (wr && (addr == ADDR_STAT) &&
		!wdata[POS_OVE] && !done |=> !overrun_flag)
		else $error("overrun flag not cleared by write of zero");
	no_txirq_a: assert property (!transmission_enable_irq)
		else $error("transmit-enable interrupt raised");
endmodule

/* File: tb/csc_peer.sv */
// Peer serial device: shifts words against the channel as slave or master
`timescale 1ns/1ps
module csc_peer (
	// Clock and resolved serial clock
	input  wire logic sys_clk,
	input  wire logic sck,
	// Data from the channel
	input  wire logic sdo,
	// Lines driven by the peer
	output logic      sdi,
	output logic      sck_out,
	output logic      sck_oe
);
	logic [15:0] send;
	logic [15:0] got;
	int          nbits = 0;
	int          cnt = 99;
	initial begin
		sdi = 1'b1;
		sck_out = 1'b1;
		sck_oe = 1'b0;
	end
	task automatic arm(input logic [15:0] w, input int n);
		send = w;
		nbits = n;
		cnt = 0;
	endtask
	// Launch late after the falling edge so the sampling edge never races
	always @(negedge sck) if (cnt < nbits) sdi <= #5 send[nbits-1-cnt];
	always @(posedge sck) if (cnt < nbits) begin
		got = {got[14:0], sdo};
		cnt++;
		// Once hold time is over the line no longer shows the last bit
		if (cnt == nbits) sdi <= #150 ~send[0];
	end
	// Clock stands high between frames and runs only inside one
	task automatic clock_frame(input int n, input int half);
		sck_oe <= 1'b1;
		repeat (n) begin
			repeat (half) @(posedge sys_clk);
			sck_out <= 1'b0;
			repeat (half) @(posedge sys_clk);
			sck_out <= 1'b1;
		end
		@(posedge sys_clk);
		sck_oe <= 1'b0;
	endtask
endmodule

/* File: tb/csc_channel_tb.sv */
// Testbench for the serial channel: register tasks and frame scenarios
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module csc_channel_tb import csc_pkg::*;;
	logic        sys_clk;
	logic        rst_n = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] rdata;
	logic        dut_sck, dut_oe, so, si, irq, tirq, p_sck, p_oe;
	wire         sck_w = dut_oe ? dut_sck : (p_oe ? p_sck : 1'b1);
	int          fails = 0;
	int          n_checks = 0;
	int          n_irq = 0;
	int          n_tirq = 0;
	int          n_edge = 0;
	int          k0;
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (irq === 1'b1) n_irq++;
		if (tirq !== 1'b0) n_tirq++;
	end
	always @(posedge sck_w) n_edge++;
	csc_channel dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .serial_clock_pin_in(sck_w),
		.serial_clock_pin_out(dut_sck), .serial_clock_pin_oe(dut_oe),
		.serial_output_pin(so), .serial_input_pin(si),
		.reception_complete_irq(irq), .transmission_enable_irq(tirq)
	);
	csc_peer peer (
		.sys_clk(sys_clk), .sck(sck_w), .sdo(so), .sdi(si),
		.sck_out(p_sck), .sck_oe(p_oe)
	);
	task automatic test_done();
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [15:0] mask(input int n);
		return 16'hFFFF >> (16 - n);
	endfunction
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [15:0] e,
		input string nm);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 `CHK(nm, e, rdata)
	endtask
	task automatic wait_irq(input int lim);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < lim) begin
			@(posedge sys_clk);
			#1 k++;
		end
		`CHK("irq", 1'b1, irq)
		@(posedge sys_clk);
		#1 `CHK("irq_pulse", 1'b0, irq)
	endtask
	// Frame started by a transmit write; a second write while busy is dropped
	task automatic tx_frame(input logic [15:0] w, input logic [15:0] pw,
		input int n, input logic [15:0] st);
		int e0;
		e0 = n_edge;
		peer.arm(pw, n);
		wr_reg(ADDR_TX, w);
		rd_chk(ADDR_STAT, 16'h0080, "busy");
		wr_reg(ADDR_TX, ~w);
		wait_irq(900);
		`CHK("edges", n, n_edge - e0)
		`CHK("sent", w & mask(n), peer.got & mask(n))
		repeat (4) @(posedge sys_clk);
		`CHK("stopped", n, n_edge - e0)
		rd_chk(ADDR_STAT, st, "done");
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++) rd_chk(a[2:0], 16'h0000, "rst");
		wr_reg(3'h6, 16'h00FF);
		rd_chk(3'h6, 16'h0000, "unmapped");
		`CHK("idle_clk", 1'b1, dut_sck)
		wr_reg(ADDR_CLOCK, 16'h0000);
		wr_reg(ADDR_LEN, 16'h0000);
		wr_reg(ADDR_MAIN, 16'h00C1);
		wr_reg(ADDR_CLOCK, 16'h0007);
		rd_chk(ADDR_CLOCK, 16'h0000, "clk_lock");
		`CHK("oe", 1'b1, dut_oe)
		tx_frame(16'h00A5, 16'h0000, 8, 16'h0000);
		tx_frame(16'h005A, 16'h0000, 8, 16'h0000);
		// Slower clock source for the receive frames
		wr_reg(ADDR_MAIN, 16'h0000);
		wr_reg(ADDR_CLOCK, 16'h0002);
		wr_reg(ADDR_MAIN, 16'h00A1);
		peer.arm(16'h00C6, 8);
		rd_chk(ADDR_RX, 16'h0000, "dummy");
		rd_chk(ADDR_STAT, 16'h0080, "rx_busy");
		wait_irq(900);
		peer.arm(16'h0039, 8);
		rd_chk(ADDR_RX, 16'h00C6, "rx_word");
		rd_chk(ADDR_STAT, 16'h0080, "restart");
		wait_irq(900);
		wr_reg(ADDR_MAIN, 16'h00A0);
		rd_chk(ADDR_RX, 16'h0039, "rx_last");
		rd_chk(ADDR_STAT, 16'h0000, "no_start");
		wr_reg(ADDR_MAIN, 16'h0000);
		wr_reg(ADDR_LEN, 16'h0008);
		wr_reg(ADDR_MAIN, 16'h00E1);
		wr_reg(ADDR_LEN, 16'h0004);
		rd_chk(ADDR_LEN, 16'h0008, "len_lock");
		tx_frame(16'h1234, 16'hBEEF, 16, 16'h0000);
		tx_frame(16'h8001, 16'h7E57, 16, 16'h0001);
		wr_reg(ADDR_STAT, 16'h0001);
		rd_chk(ADDR_STAT, 16'h0001, "ovr_w1");
		wr_reg(ADDR_STAT, 16'h0000);
		rd_chk(ADDR_STAT, 16'h0000, "ovr_w0");
		rd_chk(ADDR_RX, 16'h7E57, "rx16");
		wr_reg(ADDR_MAIN, 16'h0000);
		wr_reg(ADDR_LEN, 16'h0004);
		wr_reg(ADDR_MAIN, 16'h00E1);
		tx_frame(16'hFABC, 16'hFA5C, 12, 16'h0000);
		rd_chk(ADDR_RX, 16'h0A5C, "rx12");
		// Inverted polarity idles low; restored before the LSB-first frame
		wr_reg(ADDR_MAIN, 16'h0000);
		wr_reg(ADDR_CLOCK, 16'h0012);
		#1 `CHK("idle_inv", 1'b0, dut_sck)
		wr_reg(ADDR_CLOCK, 16'h0002);
		wr_reg(ADDR_MAIN, 16'h00F1);
		peer.arm(16'h0003, 12);
		wr_reg(ADDR_TX, 16'h0001);
		wait_irq(900);
		`CHK("lsb_tx", 16'h0800, peer.got & mask(12))
		rd_chk(ADDR_RX, 16'h0C00, "lsb_rx");
		// Slave: peer clocks two edges past the frame length
		wr_reg(ADDR_MAIN, 16'h0000);
		wr_reg(ADDR_CLOCK, 16'h0007);
		wr_reg(ADDR_LEN, 16'h0000);
		wr_reg(ADDR_MAIN, 16'h00E1);
		#1 `CHK("slave_oe", 1'b0, dut_oe)
		peer.arm(16'h00F2, 10);
		wr_reg(ADDR_TX, 16'h0096);
		repeat (20) @(posedge sys_clk);
		rd_chk(ADDR_STAT, 16'h0080, "wait_clk");
		k0 = n_irq;
		fork
			peer.clock_frame(10, 6);
			wait_irq(400);
		join
		`CHK("one_irq", k0 + 1, n_irq)
		`CHK("slave_tx", 8'h96, peer.got[9:2])
		rd_chk(ADDR_RX, 16'h003C, "slave_rx");
		wr_reg(ADDR_MAIN, 16'h0000);
		rd_chk(ADDR_STAT, 16'h0000, "off");
		`CHK("tx_irq", 0, n_tirq)
		test_done();
	end
	// Tests need about a thousand cycles; this bound only catches a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		test_done();
	end
endmodule
